//--- src/rss_reset_seq.sv
// reset source sequencer: merges reset sources, stretches the core reset, records the cause
// assumes analog comparators and the reset pin are asynchronous; watchdog and debug inputs run on core_clk
//
// What this block does
// - power-on request stays active while supply is below power-on threshold
// - supply rising above threshold starts delay counter; reset held until timeout
// - supply falling below threshold reasserts internal reset at once
// - low reset pin resets even without clock; driver must hold it long enough
// - after pin returns high, delay counter runs before processor release
// - fuse picks brown-out level: 2.7V unprogrammed, 4.0V programmed
// - enabled brown-out asserts reset when supply drops below level
// - after brown-out ends, release waits for delay counter timeout
// - brown-out dips no longer than about 2 us are ignored
// - watchdog expiry gives an internal reset pulse of one clock
// - trailing edge of watchdog pulse starts the start-up delay
// - debug reset sets bit 4; power-on or written zero clears it
// - watchdog reset sets bit 3; power-on or written zero clears it
// - brown-out reset sets bit 2; power-on or written zero clears it
// - pin reset sets bit 1; power-on or written zero clears it
// - power-on sets bit 0; only a written zero clears it
// - start-up timeout length comes from the clock select fuses
// - processor stays in reset while debug reset instruction input is high, then for the delay
// - port reset follows any active source; the supply, pin and debug reset paths need no clock
module rss_reset_seq #(
    parameter int unsigned STARTUP_BASE_CYC = rss_pkg::STARTUP_BASE_CYC_DEF
) (
    // clock and block reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // supply monitors and reset pin (asynchronous)
    input  wire logic       supply_below_por,
    input  wire logic       reset_pin_n,
    input  wire logic       bod_below_low,
    input  wire logic       bod_below_high,
    // fuses, static, high means programmed
    input  wire logic       brownout_enable_fuse,
    input  wire logic       brownout_level_select,
    input  wire logic [1:0] clock_select_fuses,
    // core-clock reset sources
    input  wire logic       watchdog_expire,
    input  wire logic       debug_port_reset_instruction,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // reset outputs
    output logic            core_reset,
    output logic            io_reset
);

    logic [3:0]       sync1_q, sync1_d, sync2_q, sync2_d;
    logic             por_s, pin_s, bod_raw_s, bod_act;
    logic [7:0]       bod_cnt_q, bod_cnt_d;
    logic             wdt_prev_q, wdt_prev_d, wdt_pulse_q, wdt_pulse_d;
    logic             src_any;
    rss_pkg::rss_seq_e state_q, state_d;
    logic [15:0]      cnt_q, cnt_d, limit;
    logic [4:0]       flags_q, flags_d;
    logic [7:0]       rdata_d;
    logic             flags_sel;

    // start-up delay length for a clock select setting
    function automatic logic [15:0] rss_timeout(input logic [1:0] sel);
        rss_timeout = 16'(STARTUP_BASE_CYC << sel);
    endfunction

    // two-flop synchronisers for the asynchronous inputs
    always_comb begin
        sync1_d = {bod_below_high, bod_below_low, ~reset_pin_n, supply_below_por};
        sync2_d = sync1_q;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    // synchronised sources and brown-out level choice
    assign por_s     = sync2_q[rss_pkg::SYN_POR];
    assign pin_s     = sync2_q[rss_pkg::SYN_PIN];
    assign bod_raw_s = brownout_enable_fuse &
                       (brownout_level_select ? sync2_q[rss_pkg::SYN_B40] : sync2_q[rss_pkg::SYN_B27]);

    // brown-out dip filter and watchdog pulse former
    always_comb begin
        bod_cnt_d   = 8'h00;
        if (bod_raw_s) begin
            bod_cnt_d = (bod_cnt_q == rss_pkg::BOD_MIN_CYC) ? bod_cnt_q : bod_cnt_q + 8'h01;
        end
        wdt_prev_d  = watchdog_expire;
        wdt_pulse_d = watchdog_expire & ~wdt_prev_q;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bod_cnt_q   <= 8'h00;
            wdt_prev_q  <= 1'b0;
            wdt_pulse_q <= 1'b0;
        end else begin
            bod_cnt_q   <= bod_cnt_d;
            wdt_prev_q  <= wdt_prev_d;
            wdt_pulse_q <= wdt_pulse_d;
        end
    end

    // brown-out counts only once the dip outlasts the minimum low time
    assign bod_act = bod_raw_s && (bod_cnt_q == rss_pkg::BOD_MIN_CYC);

    // any source holds the sequencer in reset
    assign src_any = por_s | pin_s | bod_act | wdt_pulse_q | debug_port_reset_instruction;
    assign limit   = rss_timeout(clock_select_fuses);

    // release sequencer next state
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        if (src_any) begin
            state_d = rss_pkg::SEQ_HOLD;
            cnt_d   = 16'h0000;
        end else begin
            unique case (state_q)
                rss_pkg::SEQ_HOLD: begin
                    state_d = rss_pkg::SEQ_COUNT;
                    cnt_d   = 16'h0000;
                end
                rss_pkg::SEQ_COUNT: begin
                    if (cnt_q == limit - 16'h0001) begin
                        state_d = rss_pkg::SEQ_RUN;
                    end else begin
                        cnt_d = cnt_q + 16'h0001;
                    end
                end
                rss_pkg::SEQ_RUN: begin
                    state_d = rss_pkg::SEQ_RUN;
                end
                default: begin
                    state_d = rss_pkg::SEQ_HOLD;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= rss_pkg::SEQ_HOLD;
            cnt_q   <= 16'h0000;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // reset outputs: the raw supply and pin paths need no clock
    assign core_reset = supply_below_por | ~reset_pin_n | (state_q != rss_pkg::SEQ_RUN);
    assign io_reset   = supply_below_por | ~reset_pin_n | src_any;

    // cause flags: written zeros clear, sources set, set wins over clear
    assign flags_sel = (reg_addr == rss_pkg::REG_FLAGS_ADDR);

    always_comb begin
        flags_d = flags_q;
        if (reg_wr && flags_sel) begin
            flags_d = flags_q & reg_wdata[4:0];
        end
        if (debug_port_reset_instruction) flags_d[rss_pkg::FLAG_DEBUG] = 1'b1;
        if (wdt_pulse_q) flags_d[rss_pkg::FLAG_WDOG] = 1'b1;
        if (bod_act) flags_d[rss_pkg::FLAG_BOD] = 1'b1;
        if (pin_s) flags_d[rss_pkg::FLAG_PIN] = 1'b1;
        if (por_s) begin
            flags_d[4:1]                 = 4'h0;
            flags_d[rss_pkg::FLAG_POR]   = 1'b1;
        end
        rdata_d = 8'h00;
        if (reg_rd && flags_sel) begin
            rdata_d = {3'h0, flags_q};
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q   <= rss_pkg::FLAGS_RESET;
            reg_rdata <= 8'h00;
        end else begin
            flags_q   <= flags_d;
            reg_rdata <= rdata_d;
        end
    end

    // checks on the sequencer and flags
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_por_hold: assert property (supply_below_por |-> core_reset)
        else $error("core reset low while supply below power-on level");
    a_por_reassert: assert property (por_s |=> state_q == rss_pkg::SEQ_HOLD ##1 state_q != rss_pkg::SEQ_RUN)
        else $error("power-on did not return sequencer to hold");
    a_pin_hold: assert property (!reset_pin_n |-> core_reset)
        else $error("core reset low while reset pin low");
    a_count_done: assert property (state_q == rss_pkg::SEQ_COUNT && cnt_q == limit - 16'h0001 && !src_any
                                   |=> state_q == rss_pkg::SEQ_RUN && !core_reset)
        else $error("release missing at end of start-up count");
    a_count_early: assert property ($rose(state_q == rss_pkg::SEQ_RUN)
                                    |-> $past(cnt_q) == limit - 16'h0001)
        else $error("release before full start-up count");
    a_bod_filter: assert property (bod_act |-> $past(bod_raw_s, 250))
        else $error("brown-out accepted before minimum low time");
    a_bod_reset: assert property (bod_act |=> core_reset)
        else $error("brown-out did not hold core reset");
    a_wdt_pulse: assert property (wdt_pulse_q |=> !wdt_pulse_q)
        else $error("watchdog reset pulse longer than one cycle");
    a_wdt_start: assert property (wdt_pulse_q ##1 !src_any |=> state_q == rss_pkg::SEQ_COUNT)
        else $error("delay did not start after watchdog pulse");
    a_wdt_flag: assert property (wdt_pulse_q && !por_s |=> flags_q[rss_pkg::FLAG_WDOG])
        else $error("watchdog flag not set");
    a_debug_hold: assert property (debug_port_reset_instruction |=> core_reset)
        else $error("debug reset did not hold core reset");
    a_por_flag: assert property (flags_q[rss_pkg::FLAG_POR] && !(reg_wr && flags_sel && !reg_wdata[0])
                                 |=> flags_q[rss_pkg::FLAG_POR])
        else $error("power-on flag lost without software clear");
    a_read_data: assert property (reg_rd && flags_sel |=> reg_rdata == {3'h0, $past(flags_q)})
        else $error("flag read data wrong");

    // cause flag setting and clearing, flag read data
    a_pin_flag: assert property (pin_s && !por_s |=> flags_q[rss_pkg::FLAG_PIN])
        else $error("pin flag not set");

    a_bod_flag: assert property (bod_act && !por_s |=> flags_q[rss_pkg::FLAG_BOD])
        else $error("brown-out flag not set");

    a_debug_flag: assert property (debug_port_reset_instruction && !por_s |=> flags_q[rss_pkg::FLAG_DEBUG])
        else $error("debug flag not set");

    a_por_clear: assert property (por_s |=> flags_q[4:1] == 4'h0 && flags_q[rss_pkg::FLAG_POR])
        else $error("power-on did not leave only the power-on flag");

    a_wdog_clear: assert property (reg_wr && flags_sel && !reg_wdata[rss_pkg::FLAG_WDOG] && !wdt_pulse_q && !por_s
                                   |=> !flags_q[rss_pkg::FLAG_WDOG])
        else $error("written zero did not clear watchdog flag");

    a_rdata_idle: assert property (!(reg_rd && flags_sel) |=> reg_rdata == 8'h00)
        else $error("read data not zero outside read answer");

    a_rdata_high: assert property (reg_rdata[7:5] == 3'h0)
        else $error("unused read data bits not zero");

    // sequencer stepping
    a_wdt_rise: assert property (watchdog_expire && !wdt_prev_q |=> wdt_pulse_q)
        else $error("watchdog expiry gave no reset pulse");

    a_hold_step: assert property (state_q == rss_pkg::SEQ_HOLD && !src_any
                                  |=> state_q == rss_pkg::SEQ_COUNT && cnt_q == 16'h0000)
        else $error("count did not start once sources went inactive");

    a_count_step: assert property (state_q == rss_pkg::SEQ_COUNT && cnt_q != limit - 16'h0001 && !src_any
                                   |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("start-up count did not advance");

    a_src_hold: assert property (src_any |=> state_q == rss_pkg::SEQ_HOLD)
        else $error("active source did not hold sequencer");

    a_hold_zero: assert property (state_q == rss_pkg::SEQ_HOLD |-> cnt_q == 16'h0000)
        else $error("count not cleared while held");

    a_run_release: assert property (state_q == rss_pkg::SEQ_RUN && !supply_below_por && reset_pin_n
                                    |-> !core_reset)
        else $error("core reset high while running with no source");

    // brown-out filter and port reset
    a_bod_off: assert property (!brownout_enable_fuse |-> !bod_act)
        else $error("brown-out accepted while disabled");

    a_filter_reset: assert property (!bod_raw_s |=> bod_cnt_q == 8'h00)
        else $error("brown-out filter not cleared after dip");

    a_bod_count: assert property (bod_raw_s && bod_cnt_q != rss_pkg::BOD_MIN_CYC
                                  |=> bod_cnt_q == $past(bod_cnt_q) + 8'h01)
        else $error("brown-out filter did not advance");

    a_pin_io: assert property (!reset_pin_n |-> io_reset)
        else $error("port reset low while reset pin low");

    a_dbg_io: assert property (debug_port_reset_instruction |-> io_reset)
        else $error("port reset low while debug reset held");

endmodule

//--- src/rss_pkg.sv
// constants shared by the reset source sequencer
// assumes a single 125 MHz core clock and a byte-wide register port
package rss_pkg;

    // clock and brown-out filter timing
    localparam int         CLK_PERIOD_NS   = 8;
    localparam int         BOD_MIN_TIME_NS = 2000;
    localparam logic [7:0] BOD_MIN_CYC     = 8'((BOD_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // default start-up delay base, scaled by the clock select fuses
    localparam int unsigned STARTUP_BASE_CYC_DEF = 1024;

    // register map
    localparam logic [7:0] REG_FLAGS_ADDR = 8'h00;

    // reset cause flag positions and reset value
    localparam int         FLAG_DEBUG  = 4;
    localparam int         FLAG_WDOG   = 3;
    localparam int         FLAG_BOD    = 2;
    localparam int         FLAG_PIN    = 1;
    localparam int         FLAG_POR    = 0;
    localparam logic [4:0] FLAGS_RESET = 5'h01;

    // synchroniser bit positions
    localparam int SYN_POR = 0;
    localparam int SYN_PIN = 1;
    localparam int SYN_B27 = 2;
    localparam int SYN_B40 = 3;

    // release sequencer states, gray along hold, count, run
    typedef enum logic [1:0] {
        SEQ_HOLD  = 2'h0,
        SEQ_COUNT = 2'h1,
        SEQ_RUN   = 2'h3
    } rss_seq_e;

endpackage

//--- bench/rss_pin_src.sv
// pin source model: an outside party driving the active-low reset pin
// assumes a pull-up on the pin, so a released pin reads high
module rss_pin_src #(
    parameter int MIN_LOW_CYC = 7
) (
    // clock and request
    input  wire logic       core_clk,
    input  wire logic       go,
    input  wire logic [7:0] low_cyc,
    // driven pin
    output wire logic       reset_pin_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cnt_q = 8'h00;
    // low time is never shorter than the minimum pulse width
    always @(posedge core_clk) begin
        if (go && cnt_q == 8'h00) cnt_q <= (low_cyc < 8'(MIN_LOW_CYC)) ? 8'(MIN_LOW_CYC) : low_cyc;
        else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
    end
    // the pull-up takes the pin high once released
    assign reset_pin_n = (cnt_q == 8'h00);
endmodule

//--- bench/rss_reset_seq_tb.sv
// self-checking bench for the reset source sequencer
// assumes rss_pkg, rss_reset_seq and rss_pin_src are compiled first
module rss_reset_seq_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int B = 4;
    logic       core_clk, rst_n, supply_below_por, bod_below_low, bod_below_high, go;
    logic       brownout_enable_fuse, brownout_level_select, watchdog_expire, dbg;
    logic [1:0] clock_select_fuses;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, low_cyc;
    logic       reg_wr, reg_rd, core_reset, io_reset;
    wire        reset_pin_n;
    int         n_mismatch = 0, n_tests = 0, n_io = 0;

    rss_reset_seq #(.STARTUP_BASE_CYC(B)) i_rss_reset_seq (.core_clk(core_clk), .rst_n(rst_n),
        .supply_below_por(supply_below_por), .reset_pin_n(reset_pin_n), .bod_below_low(bod_below_low),
        .bod_below_high(bod_below_high), .brownout_enable_fuse(brownout_enable_fuse),
        .brownout_level_select(brownout_level_select), .clock_select_fuses(clock_select_fuses),
        .watchdog_expire(watchdog_expire), .debug_port_reset_instruction(dbg), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .core_reset(core_reset), .io_reset(io_reset));
    rss_pin_src i_rss_pin_src (.core_clk(core_clk), .go(go), .low_cyc(low_cyc), .reset_pin_n(reset_pin_n));

    // clock, port reset high-cycle counter and hang guard
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(negedge core_clk) if (io_reset === 1'b1) n_io++;
    initial begin
        #200us;
        n_mismatch++;
        finish_test();
    end

    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(string w, logic [7:0] seen, logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", w, exp, seen);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge core_clk);
    endtask
    // read, compare, then see the data fall back to zero
    task automatic rd(logic [7:0] a, string w, logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(w, reg_rdata, e);
        @(posedge core_clk);
        #1 chk("rdata_idle", reg_rdata, 8'h00);
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // counts cycles until core reset drops, expects lo to lo+5
    task automatic rel(int lo, string w);
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            #1 n++;
        end while (core_reset === 1'b1 && n < 600);
        chk(w, 8'(n >= lo && n <= lo + 5), 8'h01);
        $display("test %s done", w);
    endtask
    task automatic brownout_detect(logic en, logic lv, logic lo, logic hi, int cyc, string w, logic e);
        @(posedge core_clk);
        brownout_enable_fuse <= en;
        brownout_level_select <= lv;
        bod_below_low <= lo;
        bod_below_high <= hi;
        step(cyc);
        #1 chk(w, 8'(core_reset), 8'(e));
        @(posedge core_clk);
        bod_below_low <= 1'b0;
        bod_below_high <= 1'b0;
    endtask

    // main sequence
    initial begin
        {rst_n, bod_below_low, bod_below_high, brownout_enable_fuse, brownout_level_select} = '0;
        {watchdog_expire, dbg, reg_wr, reg_rd, go} = '0;
        {reg_addr, reg_wdata} = '0;
        supply_below_por = 1'b1;
        clock_select_fuses = 2'h1;
        low_cyc = 8'h0A;
        step(3);
        rst_n <= 1'b1;
        step(20);
        #1 chk("por_hold", 8'(core_reset), 8'h01);
        @(posedge core_clk) supply_below_por <= 1'b0;
        rel(2 * B + 1, "power_on");
        rd(8'h00, "flags_por", 8'h01);
        wr(8'h00, 8'hFF);
        wr(8'h05, 8'h00);
        rd(8'h00, "flags_keep", 8'h01);
        rd(8'h05, "unmapped", 8'h00);
        wr(8'h00, 8'h00);
        rd(8'h00, "flags_clr", 8'h00);
        @(posedge core_clk);
        clock_select_fuses <= 2'h0;
        go <= 1'b1;
        @(posedge core_clk) go <= 1'b0;
        #1 chk("pin_core", 8'(core_reset), 8'h01);
        chk("pin_io", 8'(io_reset), 8'h01);
        rel(B + 10, "pin");
        rd(8'h00, "flags_pin", 8'h02);
        @(posedge core_clk);
        clock_select_fuses <= 2'h2;
        watchdog_expire <= 1'b1;
        n_io = 0;
        @(posedge core_clk);
        rel(4 * B + 1, "watchdog");
        chk("wdog_pulse", 8'(n_io), 8'h01);
        watchdog_expire <= 1'b0;
        rd(8'h00, "flags_wdog", 8'h0A);
        wr(8'h00, 8'hF7);
        rd(8'h00, "flags_wdog_clr", 8'h02);
        @(posedge core_clk) clock_select_fuses <= 2'h3;
        brownout_detect(1'b0, 1'b0, 1'b1, 1'b1, 300, "bod_off", 1'b0);
        brownout_detect(1'b1, 1'b0, 1'b1, 1'b1, 240, "bod_short", 1'b0);
        brownout_detect(1'b1, 1'b0, 1'b0, 1'b1, 300, "bod_lvl_low", 1'b0);
        brownout_detect(1'b1, 1'b1, 1'b0, 1'b1, 300, "bod_lvl_high", 1'b1);
        rel(8 * B - 1, "brownout");
        rd(8'h00, "flags_bod", 8'h06);
        @(posedge core_clk);
        clock_select_fuses <= 2'h1;
        dbg <= 1'b1;
        step(30);
        #1 chk("dbg_hold", 8'(core_reset), 8'h01);
        @(posedge core_clk) dbg <= 1'b0;
        rel(2 * B, "debug");
        rd(8'h00, "flags_dbg", 8'h16);
        @(posedge core_clk) supply_below_por <= 1'b1;
        #1 chk("por_again", 8'(core_reset), 8'h01);
        step(5);
        rd(8'h00, "flags_por2", 8'h01);
        finish_test();
    end
endmodule
